// ### core/wor_option_register.sv
// write-once option register with undervoltage reset control
// Function
// - only the first write to the setup offset after reset is taken; later writes ignored until reset
// - both undervoltage enables set: reset after nine cycles below falling trip
// - undervoltage reset held until supply rises above the rising trip level
// - alignment bit 1 selects edge-aligned pwm, 0 center-aligned
// - low-side invert bit 1 gives negative polarity, 0 positive
// - high-side invert bit 1 gives negative polarity, 0 positive
// - pairing bit 1 gives six independent channels, 0 three pairs
// - undervolt power bit 1 enables the undervoltage monitor
// - undervolt reset bit 1 lets the monitor reset the system
// - stop-allow bit 1 runs stop normally, 0 makes it illegal
// - watchdog-off bit 1 stops the watchdog, 0 leaves it running
//
// Design decisions made here: the register offsets and the plain strobed port.
module wor_option_register (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // register port
   input wire logic [3:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrStrobe,
   input wire logic regRdStrobe,
   output logic [7:0] regRdData,
   // undervoltage comparator pins
   input wire logic belowFallingTrip,
   input wire logic aboveRisingTrip,
   // option levels
   output logic edgeAlignSelect,
   output logic low_side_invert,
   output logic high_side_invert,
   output logic pwm_pairing_select,
   output logic undervolt_power_en,
   output logic undervolt_reset_en,
   output logic stop_instr_allow,
   output logic watchdog_off,
   // status
   output logic setupLocked,
   output logic undervoltResetReq
);

   // reset release stages
   logic rstSync1;
   logic rstSync2;

   // comparator synchroniser stages
   logic fallSync1;
   logic fallSync2;
   logic riseSync1;
   logic riseSync2;

   // option byte and its lock
   logic [7:0] setupReg;
   logic [7:0] next_setupReg;
   logic locked;
   logic next_locked;

   // read path
   logic [7:0] next_regRdData;

   // undervoltage filter
   wor_pkg::wor_uv_state_t uvState;
   wor_pkg::wor_uv_state_t next_uvState;
   logic [3:0] uvCount;
   logic [3:0] next_uvCount;

   // address decode, shared by the write and the read path
   function automatic logic isSetupAddr(input logic [3:0] addr);
      return addr == wor_pkg::SETUP_OFFSET;
   endfunction

   // one option bit out of the byte
   function automatic logic optionBit(input logic [7:0] value, input int pos);
      return value[pos];
   endfunction

   // the count has reached the last qualifying cycle
   function automatic logic filterDone(input logic [3:0] count);
      return count >= wor_pkg::UV_FILTER_COUNT - 4'h1;
   endfunction

   // count step kept in four bits
   function automatic logic [3:0] countStep(input logic [3:0] count);
      return count + 4'h1;
   endfunction

   wire logic resetN = rstSync2;

   // register port decode
   wire logic writeHit = regWrStrobe && isSetupAddr(regAddr);
   wire logic readHit = regRdStrobe && isSetupAddr(regAddr);
   wire logic takeWrite = writeHit && !locked;
   wire logic [7:0] readValue = readHit ? setupReg : 8'h00;

   // undervoltage qualification
   wire logic uvPowerOn = optionBit(setupReg, wor_pkg::UV_PWR_BIT);
   wire logic uvResetOn = optionBit(setupReg, wor_pkg::UV_RST_BIT);
   wire logic uvArmed = uvPowerOn && uvResetOn;
   wire logic supplyLow = fallSync2;
   wire logic supplyBack = riseSync2;
   wire logic uvQualify = uvArmed && supplyLow;

   // reset release through two flops
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rstSync1 <= 1'b0;
         rstSync2 <= 1'b0;
      end else begin
         rstSync1 <= 1'b1;
         rstSync2 <= rstSync1;
      end
   end

   // comparator levels come from analog pins and may move at any time
   always_ff @(posedge ref_clk or negedge resetN) begin
      if (!resetN) begin
         fallSync1 <= 1'b0;
         fallSync2 <= 1'b0;
      end else begin
         fallSync1 <= belowFallingTrip;
         fallSync2 <= fallSync1;
      end
   end

   always_ff @(posedge ref_clk or negedge resetN) begin
      if (!resetN) begin
         riseSync1 <= 1'b0;
         riseSync2 <= 1'b0;
      end else begin
         riseSync1 <= aboveRisingTrip;
         riseSync2 <= riseSync1;
      end
   end

   // next option byte: only an unlocked write to the setup address lands
   always_comb begin
      next_setupReg = setupReg;
      if (takeWrite) begin
         next_setupReg = regWrData;
      end
   end

   // the lock only ever sets; reset alone opens it again
   always_comb begin
      next_locked = locked;
      if (takeWrite) begin
         next_locked = 1'b1;
      end
   end

   // read data stand for one cycle and are zero otherwise
   always_comb begin
      next_regRdData = readValue;
   end

   always_ff @(posedge ref_clk or negedge resetN) begin
      if (!resetN) begin
         setupReg <= wor_pkg::SETUP_RESET;
      end else begin
         setupReg <= next_setupReg;
      end
   end

   always_ff @(posedge ref_clk or negedge resetN) begin
      if (!resetN) begin
         locked <= 1'b0;
      end else begin
         locked <= next_locked;
      end
   end

   always_ff @(posedge ref_clk or negedge resetN) begin
      if (!resetN) begin
         regRdData <= 8'h00;
      end else begin
         regRdData <= next_regRdData;
      end
   end

   // undervoltage filter and hold: state sequence
   always_comb begin
      next_uvState = uvState;
      unique case (uvState)
         wor_pkg::UV_IDLE: begin
            if (uvQualify) begin
               next_uvState = wor_pkg::UV_FILTER;
            end
         end
         wor_pkg::UV_FILTER: begin
            if (!uvQualify) begin
               next_uvState = wor_pkg::UV_IDLE;
            end else if (filterDone(uvCount)) begin
               next_uvState = wor_pkg::UV_HOLD;
            end
         end
         wor_pkg::UV_HOLD: begin
            if (supplyBack) begin
               next_uvState = wor_pkg::UV_IDLE;
            end
         end
      endcase
   end

   // any drop or disarm while filtering restarts the count from zero
   always_comb begin
      next_uvCount = uvCount;
      unique case (uvState)
         wor_pkg::UV_IDLE: begin
            next_uvCount = uvQualify ? 4'h1 : 4'h0;
         end
         wor_pkg::UV_FILTER: begin
            if (!uvQualify) begin
               next_uvCount = 4'h0;
            end else if (!filterDone(uvCount)) begin
               next_uvCount = countStep(uvCount);
            end
         end
         wor_pkg::UV_HOLD: begin
            if (supplyBack) begin
               next_uvCount = 4'h0;
            end
         end
      endcase
   end

   // the hold state sits in the raw reset domain so the request survives
   // the system reset it causes; only rst_b or a rise above the rising trip clears it
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         uvState <= wor_pkg::UV_IDLE;
      end else begin
         uvState <= next_uvState;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         uvCount <= 4'h0;
      end else begin
         uvCount <= next_uvCount;
      end
   end

   // status levels
   assign undervoltResetReq = uvState == wor_pkg::UV_HOLD;
   assign setupLocked = locked;

   // option levels stay steady from the first setup write until the next reset
   assign edgeAlignSelect = optionBit(setupReg, wor_pkg::EDGE_BIT);
   assign low_side_invert = optionBit(setupReg, wor_pkg::LOW_INV_BIT);
   assign high_side_invert = optionBit(setupReg, wor_pkg::HIGH_INV_BIT);
   assign pwm_pairing_select = optionBit(setupReg, wor_pkg::PAIR_BIT);
   assign undervolt_power_en = uvPowerOn;
   assign undervolt_reset_en = uvResetOn;
   assign stop_instr_allow = optionBit(setupReg, wor_pkg::STOP_BIT);
   assign watchdog_off = optionBit(setupReg, wor_pkg::WDOG_BIT);

endmodule

// ### core/wor_pkg.sv
// constants for the write-once option register
package wor_pkg;
   // register offset on the plain port
   localparam logic [3:0] SETUP_OFFSET = 4'h0;
   // field positions
   localparam int EDGE_BIT = 7;
   localparam int LOW_INV_BIT = 6;
   localparam int HIGH_INV_BIT = 5;
   localparam int PAIR_BIT = 4;
   localparam int UV_PWR_BIT = 3;
   localparam int UV_RST_BIT = 2;
   localparam int STOP_BIT = 1;
   localparam int WDOG_BIT = 0;
   // reset value of the option byte
   localparam logic [7:0] SETUP_RESET = 8'h00;
   // undervoltage filter: processor cycles below the falling trip
   localparam int UV_FILTER_CYCLES = 9;
   localparam logic [3:0] UV_FILTER_COUNT = 4'(UV_FILTER_CYCLES);
   typedef enum logic [1:0] {UV_IDLE, UV_FILTER, UV_HOLD} wor_uv_state_t;
endpackage

// ### verification/wor_option_register_props.sv
// assertion checker for the write-once option register
module wor_checker (
   // clock, reset and register port
   input wire logic ref_clk, rst_b, regWrStrobe, regRdStrobe,
   input wire logic [3:0] regAddr,
   input wire logic [7:0] regWrData, regRdData,
   // comparator pins, status and option levels
   input wire logic belowFallingTrip, aboveRisingTrip, setupLocked, undervoltResetReq,
   input wire logic edgeAlignSelect, low_side_invert, high_side_invert, pwm_pairing_select,
   input wire logic undervolt_power_en, undervolt_reset_en, stop_instr_allow, watchdog_off
);
   wire logic [7:0] opts = {edgeAlignSelect, low_side_invert, high_side_invert,
      pwm_pairing_select, undervolt_power_en, undervolt_reset_en, stop_instr_allow, watchdog_off};
   wire logic arm = undervolt_power_en && undervolt_reset_en;
   wire logic low = arm && belowFallingTrip;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   property p_take;
      regWrStrobe && regAddr == 4'h0 && !setupLocked |=> setupLocked && opts == $past(regWrData);
   endproperty
   a_take: assert property (p_take) else $error("first write not taken");
   property p_keep; setupLocked |=> setupLocked && $stable(opts); endproperty
   a_keep: assert property (p_keep) else $error("locked options moved");
   property p_rd; regRdStrobe && regAddr == 4'h0 |=> regRdData == $past(opts); endproperty
   a_rd: assert property (p_rd) else $error("read data wrong");
   property p_rdz; !(regRdStrobe && regAddr == 4'h0) |=> regRdData == 8'h00; endproperty
   a_rdz: assert property (p_rdz) else $error("read data not zero");
   property p_noarm; !arm && !undervoltResetReq |=> !undervoltResetReq; endproperty
   a_noarm: assert property (p_noarm) else $error("reset while not armed");
   property p_fire; low [*8] ##1 low [*4] |-> ##[0:2] undervoltResetReq; endproperty
   a_fire: assert property (p_fire) else $error("undervoltage reset missing");
   property p_early;
      $rose(undervoltResetReq) |-> $past(belowFallingTrip, 4) && $past(belowFallingTrip, 10);
   endproperty
   a_early: assert property (p_early) else $error("undervoltage reset too early");
   property p_hold; (undervoltResetReq && !aboveRisingTrip) [*3] |=> undervoltResetReq; endproperty
   a_hold: assert property (p_hold) else $error("reset released early");
   property p_rel; aboveRisingTrip [*5] |-> !undervoltResetReq; endproperty
   a_rel: assert property (p_rel) else $error("reset not released");
   cover property (regWrStrobe && setupLocked);
   cover property ($rose(undervoltResetReq));
   cover property (regRdStrobe && regAddr != 4'h0);
endmodule
bind wor_option_register wor_checker chk_u (.*);

// ### verification/write_once_option_register_tb.sv
// self-checking bench for the write-once option register
module write_once_option_register_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk = 0, rst_b = 0, regWrStrobe = 0, regRdStrobe = 0, pend = 0;
   logic belowFallingTrip = 0, aboveRisingTrip = 0;
   logic [3:0] regAddr = 4'h0;
   logic [7:0] regWrData = 8'h00, d, regRdData;
   logic edgeAlignSelect, low_side_invert, high_side_invert, pwm_pairing_select;
   logic undervolt_power_en, undervolt_reset_en, stop_instr_allow, watchdog_off;
   logic setupLocked, undervoltResetReq;
   logic [7:0] expQ[$];
   int fails = 0, checks = 0;
   wor_option_register dut_u (.*);
   wire logic [7:0] opts = {edgeAlignSelect, low_side_invert, high_side_invert,
      pwm_pairing_select, undervolt_power_en, undervolt_reset_en, stop_instr_allow, watchdog_off};
   always #25 ref_clk = ~ref_clk;
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic test_done();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // strobes stay up until the next call, so back-to-back cycles never double-assign
   task automatic op(input logic w, r, input logic [3:0] a, input logic [7:0] v);
      if (r) expQ.push_back(v);
      {regWrStrobe, regRdStrobe, regAddr, regWrData} <= {w, r, a, v};
      @(posedge ref_clk);
   endtask
   task automatic rst();
      rst_b <= 1'b0;
      repeat (4) @(posedge ref_clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge ref_clk);
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   always @(posedge ref_clk) begin
      if (pend) cmp(regRdData, expQ.pop_front());
      pend <= regRdStrobe;
   end
   initial begin
      #50us;
      fails++;
      test_done();
   end
   initial begin
      void'($urandom(25));
      rst();
      op(0, 1, 4'h0, 8'h00);
      cmp({7'h00, setupLocked}, 8'h00);
      d = $urandom;
      op(1, 0, 4'h0, d);
      op(1, 0, 4'h0, ~d);
      op(0, 1, 4'h0, d);
      op(0, 1, 4'h5, 8'h00);
      op(0, 0, 4'h0, 8'h00);
      cmp(opts, d);
      cmp({7'h00, setupLocked}, 8'h01);
      for (int i = 0; i < 8; i++) begin
         rst();
         op(1, 0, 4'hF, 8'hFF);
         op(1, 0, 4'h0, 8'h01 << i);
         op(0, 0, 4'h0, 8'h00);
         cmp(opts, 8'h01 << i);
      end
      rst();
      op(1, 0, 4'h0, 8'h0C);
      op(0, 0, 4'h0, 8'h00);
      belowFallingTrip <= 1'b1;
      wt(8);
      belowFallingTrip <= 1'b0;
      wt(4);
      cmp({7'h00, undervoltResetReq}, 8'h00);
      belowFallingTrip <= 1'b1;
      wt(14);
      belowFallingTrip <= 1'b0;
      wt(10);
      cmp({7'h00, undervoltResetReq}, 8'h01);
      aboveRisingTrip <= 1'b1;
      wt(6);
      cmp({7'h00, undervoltResetReq}, 8'h00);
      aboveRisingTrip <= 1'b0;
      rst();
      test_done();
   end
endmodule
